// File: logic/rsl_consts.svh
// Purpose: shared constants of the RS-485 slave link front end
// Assumes: included by its bare name
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef RSL_CONSTS_SVH
`define RSL_CONSTS_SVH

// ==========================================================
// line rates
`define RSL_CLK_HZ 250000000
`define RSL_BAUD_9600 9600
`define RSL_BAUD_19200 19200
`define RSL_BAUD_38400 38400
`define RSL_BAUD_57600 57600
`define RSL_BAUD_115200 115200
`define RSL_RATE_9600 3'h0
`define RSL_RATE_19200 3'h1
`define RSL_RATE_38400 3'h2
`define RSL_RATE_57600 3'h3
`define RSL_RATE_115200 3'h4

// ==========================================================
// function switch positions (bit index = position - 1)
`define RSL_FSW_RATE_LSB 0
`define RSL_FSW_PROTO 4
`define RSL_FSW_ADDR_HI 7

// ==========================================================
// settings and reset values
`define RSL_PAR_NONE 2'h0
`define RSL_PAR_EVEN 2'h1
`define RSL_PAR_ODD 2'h2
`define RSL_PAR_RESET 2'h1
`define RSL_STOP2_RESET 1'h0
`define RSL_WAIT_RESET 14'h0064
`define RSL_WAIT_MAX 14'h2710
`define RSL_ADDR_BCAST 5'h00
`define RSL_ADDR_RESET 5'h00

// ==========================================================
// timing and buffer depth
`define RSL_WAIT_UNIT_US 100
`define RSL_GAP_BITS 39
`define RSL_FIFO_DEPTH 32
`define RSL_MIN_DIV 8

`endif

// File: logic/rsl_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: read data comes straight from the storage flops
`timescale 1ns/100ps
`default_nettype none
`include "rsl_consts.svh"
module rsl_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `RSL_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   rsl_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_chk
      $error("rsl_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] wr_d;
   logic [AW:0] rd_q;
   logic [AW:0] rd_d;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign f.wready = !full;
   assign f.rvalid = !empty;
   assign f.rdata = mem[rd_q[AW-1:0]];
   assign push = f.wvalid && !full && ce;
   assign pop = f.rready && !empty && ce;

   // ==========================================================
   // pointers
   always_comb
   begin
      wr_d = wr_q;
      rd_d = rd_q;
      if (push)
      begin
         wr_d = wr_q + (AW+1)'(1);
      end
      if (pop)
      begin
         rd_d = rd_q + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // storage needs no reset: nothing reads a word before it is written
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q[AW-1:0]] <= f.wdata;
      end
   end
endmodule
`default_nettype wire

// File: logic/rsl_fifo_if.sv
// Purpose: carrier between the link core and its receive buffer
// Assumes: single clock domain
// Notes: valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
interface rsl_fifo_if #(parameter int W = 8);
   logic [W-1:0] wdata;
   logic wvalid;
   logic wready;
   logic [W-1:0] rdata;
   logic rvalid;
   logic rready;
   modport fifo (input wdata, input wvalid, output wready,
                 output rdata, output rvalid, input rready);
   modport src (output wdata, output wvalid, input wready);
   modport snk (input rdata, input rvalid, output rready);
endinterface
`default_nettype wire

// File: logic/rsl_link.sv
// Purpose: RS-485 half-duplex slave front end for an RTU style query/response link
// Assumes: all inputs synchronous to CLK; reset stands for power-up
// Notes: query bytes of an accepted frame pass through a 32-word FIFO
// Behaviour
// - only the master starts; transmit solely as the answer to an addressed query.
// - characters carry 8 data bits, optional even/odd parity, one or two stops.
// - bit rates 9600, 19200, 38400, 57600 and 115200 are supported.
// - rate switches 000..100, position 3 most significant, pick those rates in order.
// - all rate switches off gives 9600.
// - protocol is selected only when function switch position five is on.
// - address is rotary digit low four bits, position eight as bit four.
// - address zero is broadcast; configurer never assigns zero to a device.
// - factory address is rotary zero with position eight off.
// - switches are latched only at power-up.
// - parity, stop and waiting time settings take effect after power cycle.
// - broadcast queries are executed but never answered.
// - parity code 0 none, 1 even, 2 odd; even after reset.
// - waiting time 0..10000 in 0.1 ms steps delays the answer; reset 100.
`timescale 1ns/100ps
`default_nettype none
`include "rsl_consts.svh"
module rsl_link #(
   parameter int CLK_HZ = `RSL_CLK_HZ,
   parameter int WAIT_UNIT_CYC = CLK_HZ / 1000000 * `RSL_WAIT_UNIT_US
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic [7:0] COMM_FUNC_SW,
   input wire logic [3:0] ADDR_ROTARY_SW,
   input wire logic [1:0] CFG_PARITY,
   input wire logic CFG_STOP_TWO,
   input wire logic [13:0] CFG_TX_WAIT,
   input wire logic LINE_RX,
   output logic LINE_TX,
   output logic LINE_TX_OE_B,
   output logic MODBUS_SEL,
   output logic [4:0] SLAVE_ADDR,
   output logic RATE_VALID,
   output logic [7:0] RX_DATA,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic RX_FRAME_END,
   output logic RX_FRAME_BCAST,
   output logic RX_FRAME_BAD,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_VALID,
   input wire logic TX_LAST,
   output logic TX_READY,
   output logic TX_BUSY
);
   localparam int DIVW = 16;
   localparam int GAPW = 22;
   localparam int UW = $clog2(WAIT_UNIT_CYC + 1);

   if (CLK_HZ / `RSL_BAUD_9600 > 65535 || CLK_HZ / `RSL_BAUD_115200 < `RSL_MIN_DIV ||
       WAIT_UNIT_CYC < 1)
   begin : g_chk
      $error("rsl_link: clock rate cannot serve the bit rates or waiting time");
   end

   function automatic logic [DIVW-1:0] div_of(input int baud);
      return DIVW'((CLK_HZ + baud / 2) / baud);
   endfunction

   // ==========================================================
   // power-up configuration latch
   logic cfg_done_q, cfg_done_d;
   logic modbus_q, modbus_d;
   logic [4:0] addr_q, addr_d;
   logic rate_ok_q, rate_ok_d;
   logic [DIVW-1:0] div_q, div_d;
   logic [GAPW-1:0] gap_lim_q, gap_lim_d;
   rsl_pkg::rsl_par_t par_q, par_d;
   logic stop2_q, stop2_d;
   logic [13:0] wait_q, wait_d;

   always_comb
   begin
      cfg_done_d = 1'h1;
      modbus_d = modbus_q;
      addr_d = addr_q;
      rate_ok_d = rate_ok_q;
      div_d = div_q;
      par_d = par_q;
      stop2_d = stop2_q;
      wait_d = wait_q;
      gap_lim_d = gap_lim_q;
      // sampled once after reset release, later switch moves are ignored
      if (!cfg_done_q)
      begin
         modbus_d = COMM_FUNC_SW[`RSL_FSW_PROTO];
         addr_d = {COMM_FUNC_SW[`RSL_FSW_ADDR_HI], ADDR_ROTARY_SW};
         rate_ok_d = 1'h1;
         unique case (COMM_FUNC_SW[`RSL_FSW_RATE_LSB +: 3])
            `RSL_RATE_9600: div_d = div_of(`RSL_BAUD_9600);
            `RSL_RATE_19200: div_d = div_of(`RSL_BAUD_19200);
            `RSL_RATE_38400: div_d = div_of(`RSL_BAUD_38400);
            `RSL_RATE_57600: div_d = div_of(`RSL_BAUD_57600);
            `RSL_RATE_115200: div_d = div_of(`RSL_BAUD_115200);
            default:
            begin
               // illegal code: fall back to the slowest rate and flag it
               div_d = div_of(`RSL_BAUD_9600);
               rate_ok_d = 1'h0;
            end
         endcase
         par_d = (CFG_PARITY == 2'h3) ? `RSL_PAR_RESET : CFG_PARITY;
         stop2_d = CFG_STOP_TWO;
         wait_d = (CFG_TX_WAIT > `RSL_WAIT_MAX) ? `RSL_WAIT_MAX : CFG_TX_WAIT;
         gap_lim_d = GAPW'(div_d * `RSL_GAP_BITS);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         cfg_done_q <= 1'h0;
         modbus_q <= 1'h0;
         addr_q <= `RSL_ADDR_RESET;
         rate_ok_q <= 1'h1;
         div_q <= div_of(`RSL_BAUD_9600);
         par_q <= `RSL_PAR_RESET;
         stop2_q <= `RSL_STOP2_RESET;
         wait_q <= `RSL_WAIT_RESET;
         gap_lim_q <= GAPW'(div_of(`RSL_BAUD_9600) * `RSL_GAP_BITS);
      end
      else if (CE)
      begin
         cfg_done_q <= cfg_done_d;
         modbus_q <= modbus_d;
         addr_q <= addr_d;
         rate_ok_q <= rate_ok_d;
         div_q <= div_d;
         par_q <= par_d;
         stop2_q <= stop2_d;
         wait_q <= wait_d;
         gap_lim_q <= gap_lim_d;
      end
   end

   // ==========================================================
   // receiver
   rsl_pkg::rsl_rx_st_t rx_st_q, rx_st_d;
   logic [DIVW-1:0] rx_cnt_q, rx_cnt_d;
   logic [2:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic rx_perr_q, rx_perr_d;
   logic rx_tick;
   logic byte_done;
   logic byte_err;
   logic par_odd;

   assign rx_tick = (rx_cnt_q == '0);
   assign par_odd = (par_q == `RSL_PAR_ODD);

   always_comb
   begin
      rx_st_d = rx_st_q;
      rx_cnt_d = rx_tick ? rx_cnt_q : rx_cnt_q - DIVW'(1);
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      rx_perr_d = rx_perr_q;
      byte_done = 1'h0;
      byte_err = 1'h0;
      unique case (rx_st_q)
         rsl_pkg::RX_IDLE:
         begin
            // own echo is ignored while the driver is on
            if (!LINE_RX && LINE_TX_OE_B)
            begin
               rx_st_d = rsl_pkg::RX_START;
               rx_cnt_d = div_q >> 1;
            end
         end
         rsl_pkg::RX_START:
            if (rx_tick)
            begin
               rx_st_d = LINE_RX ? rsl_pkg::RX_IDLE : rsl_pkg::RX_DATA;
               rx_cnt_d = div_q - DIVW'(1);
               rx_bit_d = 3'h0;
               rx_perr_d = 1'h0;
            end
         rsl_pkg::RX_DATA:
            if (rx_tick)
            begin
               rx_sh_d = {LINE_RX, rx_sh_q[7:1]};
               rx_cnt_d = div_q - DIVW'(1);
               rx_bit_d = rx_bit_q + 3'h1;
               if (rx_bit_q == 3'h7)
               begin
                  rx_st_d = (par_q == `RSL_PAR_NONE) ? rsl_pkg::RX_STOP : rsl_pkg::RX_PAR;
               end
            end
         rsl_pkg::RX_PAR:
            if (rx_tick)
            begin
               rx_perr_d = LINE_RX != ((^rx_sh_q) ^ par_odd);
               rx_cnt_d = div_q - DIVW'(1);
               rx_st_d = rsl_pkg::RX_STOP;
            end
         rsl_pkg::RX_STOP:
            // only the first stop bit is checked, a second one reads as idle
            if (rx_tick)
            begin
               byte_done = 1'h1;
               byte_err = !LINE_RX || rx_perr_q;
               rx_st_d = rsl_pkg::RX_IDLE;
            end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         rx_st_q <= rsl_pkg::RX_IDLE;
         rx_cnt_q <= '0;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         rx_perr_q <= 1'h0;
      end
      else if (CE)
      begin
         rx_st_q <= rx_st_d;
         rx_cnt_q <= rx_cnt_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
         rx_perr_q <= rx_perr_d;
      end
   end

   // ==========================================================
   // frame delimiting and address filter
   logic [GAPW-1:0] gap_q, gap_d;
   logic in_frame_q, in_frame_d;
   logic acc_q, acc_d;
   logic bc_q, bc_d;
   logic bad_q, bad_d;
   logic fend_q, fend_d;
   logic fbc_q, fbc_d;
   logic fbad_q, fbad_d;
   logic quiet;
   logic fend_now;
   logic permit_now;
   logic push;

   rsl_fifo_if #(.W(8)) rxf ();

   assign quiet = (rx_st_q == rsl_pkg::RX_IDLE) && LINE_RX;
   assign fend_now = in_frame_q && quiet && (gap_q == gap_lim_q - GAPW'(1));
   assign permit_now = acc_q && !bc_q && !bad_q;
   assign rxf.wdata = rx_sh_q;
   assign rxf.wvalid = push;

   always_comb
   begin
      gap_d = quiet ? ((gap_q == gap_lim_q) ? gap_q : gap_q + GAPW'(1)) : '0;
      in_frame_d = in_frame_q;
      acc_d = acc_q;
      bc_d = bc_q;
      bad_d = bad_q;
      fend_d = 1'h0;
      fbc_d = fbc_q;
      fbad_d = fbad_q;
      push = 1'h0;
      if (byte_done)
      begin
         if (!in_frame_q)
         begin
            in_frame_d = 1'h1;
            bc_d = (rx_sh_q == 8'(`RSL_ADDR_BCAST));
            acc_d = modbus_q && (bc_d || rx_sh_q == 8'(addr_q));
            bad_d = byte_err;
         end
         else
         begin
            bad_d = bad_q || byte_err || (acc_q && !rxf.wready);
         end
         push = acc_d;
      end
      else if (fend_now)
      begin
         in_frame_d = 1'h0;
         fend_d = acc_q;
         if (acc_q)
         begin
            fbc_d = bc_q;
            fbad_d = bad_q;
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         gap_q <= '0;
         in_frame_q <= 1'h0;
         acc_q <= 1'h0;
         bc_q <= 1'h0;
         bad_q <= 1'h0;
         fend_q <= 1'h0;
         fbc_q <= 1'h0;
         fbad_q <= 1'h0;
      end
      else if (CE)
      begin
         gap_q <= gap_d;
         in_frame_q <= in_frame_d;
         acc_q <= acc_d;
         bc_q <= bc_d;
         bad_q <= bad_d;
         fend_q <= fend_d;
         fbc_q <= fbc_d;
         fbad_q <= fbad_d;
      end
   end

   rsl_fifo #(.W(8), .DEPTH(`RSL_FIFO_DEPTH)) u_rx_fifo (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .f(rxf.fifo)
   );

   assign RX_DATA = rxf.rdata;
   assign RX_VALID = rxf.rvalid;
   assign rxf.rready = RX_READY;

   // ==========================================================
   // transmitter
   rsl_pkg::rsl_tx_st_t tx_st_q, tx_st_d;
   logic [DIVW-1:0] tx_cnt_q, tx_cnt_d;
   logic [UW-1:0] tu_q, tu_d;
   logic [13:0] tw_q, tw_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic tx_par_q, tx_par_d;
   logic tx_last_q, tx_last_d;
   logic txd_q, txd_d;
   logic oe_b_q, oe_b_d;
   logic tx_tick;
   logic rx_busy;

   assign tx_tick = (tx_cnt_q == '0);
   assign rx_busy = (rx_st_q != rsl_pkg::RX_IDLE);
   // unsolicited bytes are swallowed while off so the user side never hangs
   assign TX_READY = (tx_st_q == rsl_pkg::TX_OFF) || (tx_st_q == rsl_pkg::TX_ARMED);

   always_comb
   begin
      tx_st_d = tx_st_q;
      tx_cnt_d = tx_tick ? tx_cnt_q : tx_cnt_q - DIVW'(1);
      tu_d = tu_q;
      tw_d = tw_q;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_par_d = tx_par_q;
      tx_last_d = tx_last_q;
      txd_d = txd_q;
      unique case (tx_st_q)
         rsl_pkg::TX_OFF:
            if (fend_now && permit_now)
            begin
               tx_st_d = rsl_pkg::TX_WAIT;
               tw_d = wait_q;
               tu_d = UW'(WAIT_UNIT_CYC - 1);
            end
         rsl_pkg::TX_WAIT:
            // a new query from the master cancels a pending answer
            if (rx_busy)
            begin
               tx_st_d = rsl_pkg::TX_OFF;
            end
            else if (tw_q == 14'h0000)
            begin
               tx_st_d = rsl_pkg::TX_ARMED;
            end
            else if (tu_q == '0)
            begin
               tu_d = UW'(WAIT_UNIT_CYC - 1);
               tw_d = tw_q - 14'h0001;
            end
            else
            begin
               tu_d = tu_q - UW'(1);
            end
         rsl_pkg::TX_ARMED:
            if (rx_busy)
            begin
               tx_st_d = rsl_pkg::TX_OFF;
            end
            else if (TX_VALID)
            begin
               tx_sh_d = TX_DATA;
               tx_last_d = TX_LAST;
               tx_par_d = (^TX_DATA) ^ par_odd;
               tx_st_d = rsl_pkg::TX_START;
               tx_cnt_d = div_q - DIVW'(1);
               txd_d = 1'h0;
            end
         rsl_pkg::TX_START:
            if (tx_tick)
            begin
               tx_st_d = rsl_pkg::TX_DATA;
               tx_bit_d = 3'h0;
               txd_d = tx_sh_q[0];
               tx_cnt_d = div_q - DIVW'(1);
            end
         rsl_pkg::TX_DATA:
            if (tx_tick)
            begin
               tx_cnt_d = div_q - DIVW'(1);
               tx_bit_d = tx_bit_q + 3'h1;
               tx_sh_d = {1'h0, tx_sh_q[7:1]};
               txd_d = tx_sh_q[1];
               if (tx_bit_q == 3'h7)
               begin
                  tx_bit_d = 3'h0;
                  tx_st_d = (par_q == `RSL_PAR_NONE) ? rsl_pkg::TX_STOP : rsl_pkg::TX_PAR;
                  txd_d = (par_q == `RSL_PAR_NONE) ? 1'h1 : tx_par_q;
               end
            end
         rsl_pkg::TX_PAR:
            if (tx_tick)
            begin
               tx_st_d = rsl_pkg::TX_STOP;
               txd_d = 1'h1;
               tx_cnt_d = div_q - DIVW'(1);
            end
         rsl_pkg::TX_STOP:
            if (tx_tick)
            begin
               if (stop2_q && tx_bit_q == 3'h0)
               begin
                  tx_bit_d = 3'h1;
                  tx_cnt_d = div_q - DIVW'(1);
               end
               else
               begin
                  tx_st_d = tx_last_q ? rsl_pkg::TX_OFF : rsl_pkg::TX_ARMED;
               end
            end
      endcase
      oe_b_d = !(tx_st_d inside {rsl_pkg::TX_START, rsl_pkg::TX_DATA,
                                 rsl_pkg::TX_PAR, rsl_pkg::TX_STOP});
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         tx_st_q <= rsl_pkg::TX_OFF;
         tx_cnt_q <= '0;
         tu_q <= '0;
         tw_q <= 14'h0000;
         tx_bit_q <= 3'h0;
         tx_sh_q <= 8'h00;
         tx_par_q <= 1'h0;
         tx_last_q <= 1'h0;
         txd_q <= 1'h1;
         oe_b_q <= 1'h1;
      end
      else if (CE)
      begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         tu_q <= tu_d;
         tw_q <= tw_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         tx_par_q <= tx_par_d;
         tx_last_q <= tx_last_d;
         txd_q <= txd_d;
         oe_b_q <= oe_b_d;
      end
   end

   // ==========================================================
   // outputs
   assign LINE_TX = txd_q;
   assign LINE_TX_OE_B = oe_b_q;
   assign MODBUS_SEL = modbus_q;
   assign SLAVE_ADDR = addr_q;
   assign RATE_VALID = rate_ok_q;
   assign RX_FRAME_END = fend_q;
   assign RX_FRAME_BCAST = fbc_q;
   assign RX_FRAME_BAD = fbad_q;
   assign TX_BUSY = (tx_st_q != rsl_pkg::TX_OFF);
endmodule
`default_nettype wire

// File: logic/rsl_link_fix.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: logic/rsl_pkg.sv
// Purpose: types of the RS-485 slave link front end
// Assumes: nothing
// Notes: constants live in rsl_consts.svh
package rsl_pkg;
   // ==========================================================
   // state types
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rsl_rx_st_t;
   typedef enum logic [2:0] {
      TX_OFF, TX_WAIT, TX_ARMED, TX_START, TX_DATA, TX_PAR, TX_STOP
   } rsl_tx_st_t;
   typedef logic [1:0] rsl_par_t;
endpackage

// File: verification/rsl_link_sva.sv
// Purpose: port checker of the serial slave front end
// Assumes: bound into rsl_link
// Notes: switch latch is judged one edge after the first run edge
`timescale 1ns/100ps
`default_nettype none
module rsl_link_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic [7:0] COMM_FUNC_SW,
   input wire logic [3:0] ADDR_ROTARY_SW,
   input wire logic LINE_TX,
   input wire logic LINE_TX_OE_B,
   input wire logic MODBUS_SEL,
   input wire logic [4:0] SLAVE_ADDR,
   input wire logic RATE_VALID,
   input wire logic RX_FRAME_END,
   input wire logic RX_FRAME_BCAST,
   input wire logic TX_BUSY
);
   // ==========================================================
   // run edges since reset, saturating at three
   logic [1:0] up_q;
   always_ff @(posedge CLK)
   begin
      up_q <= (!RST_B) ? 2'h0 : up_q + 2'(CE && up_q != 2'h3);
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   a_addr_latch: assert property (up_q == 2'h1 |->
      SLAVE_ADDR == {$past(COMM_FUNC_SW[7]), $past(ADDR_ROTARY_SW)}) else $error("address wrong");
   a_proto_latch: assert property (up_q == 2'h1 |->
      MODBUS_SEL == $past(COMM_FUNC_SW[4])) else $error("protocol select wrong");
   a_rate_code: assert property (up_q == 2'h1 |->
      RATE_VALID == ($past(COMM_FUNC_SW[2:0]) <= 3'h4)) else $error("rate flag wrong");
   a_switch_hold: assert property (up_q == 2'h3 |->
      $stable(SLAVE_ADDR) && $stable(MODBUS_SEL) && $stable(RATE_VALID)) else $error("setting moved");
   a_start_low: assert property ($fell(LINE_TX_OE_B) |->
      (!LINE_TX && !LINE_TX_OE_B) [*8]) else $error("start bit short");
   a_idle_high: assert property (LINE_TX_OE_B |-> LINE_TX) else $error("idle tx low");
   a_drive_busy: assert property (!LINE_TX_OE_B |->
      TX_BUSY || $past(TX_BUSY)) else $error("driving while idle");
   a_answer_cause: assert property ($rose(TX_BUSY) |->
      RX_FRAME_END || $past(RX_FRAME_END) || $past(RX_FRAME_END, 2)) else $error("unsolicited");
   a_bcast_mute: assert property (RX_FRAME_END && RX_FRAME_BCAST |=>
      !TX_BUSY [*4]) else $error("broadcast answered");
   a_end_pulse: assert property (RX_FRAME_END |=> !RX_FRAME_END) else $error("end too long");
   cover property ($fell(LINE_TX_OE_B));
   cover property (RX_FRAME_END && RX_FRAME_BCAST);
   cover property (RX_FRAME_END && !RX_FRAME_BCAST);
endmodule
bind rsl_link rsl_link_chk i_rsl_link_chk (.CLK(CLK), .RST_B(RST_B), .CE(CE),
   .COMM_FUNC_SW(COMM_FUNC_SW), .ADDR_ROTARY_SW(ADDR_ROTARY_SW), .LINE_TX(LINE_TX),
   .LINE_TX_OE_B(LINE_TX_OE_B), .MODBUS_SEL(MODBUS_SEL), .SLAVE_ADDR(SLAVE_ADDR),
   .RATE_VALID(RATE_VALID), .RX_FRAME_END(RX_FRAME_END), .RX_FRAME_BCAST(RX_FRAME_BCAST),
   .TX_BUSY(TX_BUSY));
`default_nettype wire

// File: verification/rsl_master.sv
// Purpose: behavioural master controller on the shared bus
// Assumes: div is one bit time in clock cycles
// Notes: queries carry 11 bits: parity or a second stop
`timescale 1ns/100ps
`default_nettype none
module rsl_master (
   input wire logic clk,
   input wire logic [15:0] div,
   input wire logic [1:0] par,
   input wire logic tx,
   input wire logic tx_oe_b,
   output logic line
);
   // ==========================================================
   // bus, queries and reply capture
   logic drv = 1'b1;
   logic [8:0] got [$];
   // failsafe bias keeps a released bus high
   assign line = (tx_oe_b === 1'b0) ? tx : drv;
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b ^ (par == 2'h2), b, 1'b0};
      f[9] = f[9] | (par == 2'h0);
      for (int i = 0; i < 11; i++)
      begin
         drv = f[i];
         repeat (div) @(negedge clk);
      end
   endtask
   // bit 8 of each capture is high when parity held
   initial
   begin
      logic [8:0] r;
      forever
      begin
         @(negedge line iff tx_oe_b === 1'b0);
         repeat (div / 2) @(posedge clk);
         r = 9'h100;
         for (int i = 0; i < 8; i++)
         begin
            repeat (div) @(posedge clk);
            r[i] = line;
         end
         if (par != 2'h0)
         begin
            repeat (div) @(posedge clk);
            r[8] = (^r[7:0] ^ line ^ (par == 2'h2)) == 1'b0;
         end
         repeat (div) @(posedge clk);
         got.push_back(r);
      end
   end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench of the serial slave front end
// Assumes: a low clock figure shrinks every bit time
// Notes: inputs move on the falling edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ==========================================================
   // bench
   localparam int HZ = 2500000;
   logic clk = 1'b0;
   logic rst_b, ce, stop2, ms2, rxv, rxr, fend, fbc, fbad, txv, txl, txr, txb;
   logic line, ltx, oe_b, msel, rv;
   logic [7:0] fsw, rxd, txd;
   logic [3:0] rot;
   logic [1:0] cpar, mpar;
   logic [13:0] wt;
   logic [4:0] saddr;
   logic [15:0] dv;
   int bauds[5] = '{9600, 19200, 38400, 57600, 115200};
   int fail_count = 0;
   int cmp_count = 0;
   int n, k;
   always #2 clk = ~clk;
   rsl_link #(.CLK_HZ(HZ), .WAIT_UNIT_CYC(10)) i_rsl_link (.CLK(clk), .RST_B(rst_b), .CE(ce),
      .COMM_FUNC_SW(fsw), .ADDR_ROTARY_SW(rot), .CFG_PARITY(cpar), .CFG_STOP_TWO(stop2),
      .CFG_TX_WAIT(wt), .LINE_RX(line), .LINE_TX(ltx), .LINE_TX_OE_B(oe_b), .MODBUS_SEL(msel),
      .SLAVE_ADDR(saddr), .RATE_VALID(rv), .RX_DATA(rxd), .RX_VALID(rxv), .RX_READY(rxr),
      .RX_FRAME_END(fend), .RX_FRAME_BCAST(fbc), .RX_FRAME_BAD(fbad), .TX_DATA(txd),
      .TX_VALID(txv), .TX_LAST(txl), .TX_READY(txr), .TX_BUSY(txb));
   rsl_master i_rsl_master (.clk(clk), .div(dv), .par(mpar), .tx(ltx), .tx_oe_b(oe_b),
      .line(line));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo(input int lim);
      if (n >= lim)
      begin
         check("wait bound", 16'h0, 16'h1);
         close_out();
      end
   endtask
   // settings are scrambled after the latch edge; expectations keep the originals
   task automatic power_up(input logic [7:0] fs, input logic [3:0] ro, input logic [1:0] p,
      input logic s2);
      rst_b = 1'b0;
      fsw = fs;
      rot = ro;
      cpar = p;
      mpar = p;
      stop2 = s2;
      ms2 = s2;
      wt = 14'h0003;
      dv = 16'((HZ + bauds[fs[2:0]] / 2) / bauds[fs[2:0]]);
      repeat (16) @(negedge clk);
      check("reset outputs", {ltx, oe_b, txr, txb}, 4'hE);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check("address", saddr, {fs[7], ro});
      check("protocol", msel, fs[4]);
      check("rate valid", rv, 1'b1);
      fsw = ~fs;
      rot = ~ro;
      cpar = p ^ 2'h3;
      stop2 = ~s2;
      wt = 14'h0000;
   endtask
   task automatic pop(input logic [7:0] e);
      check("rx valid", rxv, 1'b1);
      check("rx data", rxd, e);
      rxr = 1'b1;
      @(negedge clk);
      rxr = 1'b0;
      @(negedge clk);
   endtask
   task automatic query(input logic [7:0] a, input logic [7:0] d, input logic bc);
      i_rsl_master.send(a);
      i_rsl_master.send(d);
      for (n = 0; n < 60 * dv && fend !== 1'b1; n++) @(negedge clk);
      tmo(60 * dv);
      check("broadcast flag", fbc, bc);
      check("bad flag", fbad, 1'b0);
      pop(a);
      pop(d);
   endtask
   task automatic answer(input logic [7:0] b);
      for (n = 0; n < 200 && !(txr === 1'b1 && txb === 1'b1); n++) @(negedge clk);
      tmo(200);
      check("wait time", n >= 24 && n <= 30, 1'b1);
      txd = b;
      txv = 1'b1;
      txl = 1'b1;
      @(negedge clk);
      txv = 1'b0;
      k = 0;
      for (n = 0; n < 14 * dv && txb !== 1'b0; n++)
      begin
         @(negedge clk);
         k = k + (oe_b === 1'b0);
      end
      tmo(14 * dv);
      n = dv * (10 + (mpar != 2'h0) + ms2);
      check("drive time", k >= n - 2 && k <= n + 2, 1'b1);
      check("reply", i_rsl_master.got[0], {1'b1, b});
      i_rsl_master.got.delete();
   endtask
   initial
   begin
      ce = 1'b1;
      rxr = 1'b0;
      txd = 8'h00;
      txv = 1'b0;
      txl = 1'b0;
      power_up(8'h00, 4'h0, 2'h1, 1'b0);
      for (int r = 0; r < 5; r++)
      begin
         power_up({4'h9, 1'b0, 3'(r)}, 4'h5, 2'(r % 3), r[0]);
         query(8'h15, 8'(8'hA0 + r), 1'b0);
         answer(8'h3C);
         check("address held", saddr, 5'h15);
      end
      i_rsl_master.send(8'h07);
      k = 0;
      for (n = 0; n < 50 * dv; n++)
      begin
         @(negedge clk);
         k = k + (fend !== 1'b0 || txb !== 1'b0 || rxv !== 1'b0);
      end
      check("foreign quiet", 16'(k), 16'h0);
      query(8'h00, 8'h11, 1'b1);
      repeat (40) @(negedge clk);
      check("broadcast mute", {txb, oe_b}, 2'h1);
      close_out();
   end
endmodule
`default_nettype wire
